/* File: mcu8_core.sv */
// Functional notes
// [RQ1] add/and/sub/compare use accumulator plus memory/immediate
// [RQ2] clear/inc/dec reach all 256 data locations
// [RQ3] complement, rotate, shift act on accumulator only
// [RQ4] add immediate: two bytes, four cycles, Z and C
// [RQ5] short inc/dec: one byte, four cycles, Z only
// [RQ6] clear direct: three bytes, four cycles, no flags
// [RQ7] shift left accumulator: two bytes, four cycles, Z C
// [RQ8] branch only when selected condition holds
// [RQ9] short jumps on C, not C, Z, not Z
// [RQ10] short jump span from -15 to +16
// [RQ11] bit test branches: three bytes, five cycles
// [RQ12] bit test copies tested bit into carry
// [RQ13] bit test displacement from -126 to +129
// [RQ14] bit set/clear reach any bit anywhere
// [RQ15] bit set/clear: two bytes, four cycles, no flags
// [RQ16] software avoids bit ops on port registers
// [RQ17] nop/ret/stop/wait: one byte, two cycles, no flags
// [RQ18] return from interrupt: one byte, two cycles, Z C
// [RQ19] watchdog selected turns stop into wait
// [RQ20] jump and call: two bytes, four cycles, no flags
// [RQ21] jump target reaches whole 12-bit program space
// [RQ22] target is opcode low nibble then next byte
// [RQ23] unaffected flags hold through the whole instruction
`default_nettype none
module mcu8_core (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    output logic [11:0] pm_addr,
    input wire logic [7:0] pm_data,
    output mcu8_pkg::ds_req_t ds_req,
    input wire logic [7:0] ds_rdata,
    input wire logic wdog_sel,
    input wire mcu8_pkg::flags_t irq_flags,
    input wire logic wake,
    output mcu8_pkg::flags_t flags,
    output logic [7:0] acc,
    output logic lp_stop,
    output logic lp_wait
);
    typedef enum logic {S_RUN, S_HALT} state_t;

    state_t state_q;
    logic [2:0] cyc_q;
    logic [11:0] pc_q, pc_d, ins_pc_q;
    logic [7:0] op_q, b2_q, b3_q, ptr_q, opnd_q;
    logic [7:0] a_q, a_d;
    mcu8_pkg::flags_t flags_q, flags_d;
    logic wr_q, wr_d;
    logic [7:0] waddr_q, waddr_d, wdata_q, rd_addr;
    logic stop_q, wait_q, halt_d;
    logic [11:0] stack_q [mcu8_pkg::STACK_DEPTH];
    logic [2:0] sp_q;

    logic [2:0] cls, fn;
    logic [1:0] md;
    logic is_rel, is_ext, is_alu, is_ctl, sd, bt, bop;
    logic alu_ind, alu_b2, alu_b3, acc_tgt, to_acc, to_mem, clr_dir;
    logic is_stop, is_ret, is_iret, fin, run, bit_val;
    logic [2:0] ncyc;
    logic [7:0] opval, alu_a, alu_res;
    logic alu_z, alu_c, alu_zwe, alu_cwe, br_taken;
    logic [11:0] br_target;
    mcu8_pkg::alu_op_t alu_op;

    assign cls = op_q[7:5];
    assign fn = op_q[4:2];
    assign md = op_q[1:0];
    assign is_rel = !op_q[7];
    assign is_ext = (cls == mcu8_pkg::CLS_EXT);
    assign is_alu = (cls == mcu8_pkg::CLS_ALU);
    assign is_ctl = (cls == mcu8_pkg::CLS_CTL);
    assign sd = is_ctl && op_q[4];
    assign bt = (cls == mcu8_pkg::CLS_BIT) && !op_q[3];
    assign bop = (cls == mcu8_pkg::CLS_BIT) && op_q[3];
    assign is_stop = is_ctl && !op_q[4] && (op_q[2:0] == mcu8_pkg::C_STOP);
    assign is_ret = is_ctl && !op_q[4] && (op_q[2:0] == mcu8_pkg::C_RET);
    assign is_iret = is_ctl && !op_q[4] && (op_q[2:0] == mcu8_pkg::C_IRET);
    assign alu_ind = is_alu && (fn != mcu8_pkg::F_ACC) && md[1];
    assign alu_b2 = is_alu && ((fn == mcu8_pkg::F_ACC) ?
                    (md == mcu8_pkg::ACC_SHL) : !md[1]); // RQ7 RQ4
    assign clr_dir = is_alu && (fn == mcu8_pkg::F_CLR)
                     && (md == mcu8_pkg::M_DIR);
    assign alu_b3 = clr_dir; // RQ6
    assign acc_tgt = (md == mcu8_pkg::M_IMM) && (fn == mcu8_pkg::F_INC
                     || fn == mcu8_pkg::F_DEC || fn == mcu8_pkg::F_CLR);
    // RQ1 RQ3
    assign to_acc = is_alu && (fn == mcu8_pkg::F_ACC || fn == mcu8_pkg::F_ADD
                    || fn == mcu8_pkg::F_AND || fn == mcu8_pkg::F_SUB
                    || acc_tgt);
    assign to_mem = (is_alu && !to_acc && fn != mcu8_pkg::F_CMP) || sd || bop;

    always_comb begin
        if (is_rel || (is_ctl && !sd)) begin
            ncyc = mcu8_pkg::CYC_SHORT; // RQ9 RQ17 RQ18
        end else if (bt) begin
            ncyc = mcu8_pkg::CYC_BTEST; // RQ11
        end else begin
            ncyc = mcu8_pkg::CYC_STD; // RQ4 RQ5 RQ6 RQ15 RQ20
        end
    end

    assign run = (state_q == S_RUN);
    assign fin = run && (cyc_q != 3'h0) && (cyc_q == ncyc - 3'h1);
    assign bit_val = opnd_q[op_q[2:0]];

    // operand value: immediate byte, accumulator or the data read
    always_comb begin
        if (is_alu && md == mcu8_pkg::M_IMM) begin
            opval = acc_tgt ? a_q : b2_q;
        end else begin
            opval = opnd_q;
        end
    end
    assign alu_a = (bop || sd || (is_alu && (fn == mcu8_pkg::F_INC
                   || fn == mcu8_pkg::F_DEC))) ? opval : a_q;

    always_comb begin
        if (bop) begin
            alu_op = op_q[4] ? mcu8_pkg::ALU_SETB
                             : mcu8_pkg::ALU_CLRB; // RQ14
        end else if (sd) begin
            alu_op = op_q[3] ? mcu8_pkg::ALU_DEC : mcu8_pkg::ALU_INC;
        end else begin
            unique case (fn)
                mcu8_pkg::F_ADD: alu_op = mcu8_pkg::ALU_ADD;
                mcu8_pkg::F_AND: alu_op = mcu8_pkg::ALU_AND;
                mcu8_pkg::F_SUB: alu_op = mcu8_pkg::ALU_SUB;
                mcu8_pkg::F_CMP: alu_op = mcu8_pkg::ALU_CMP;
                mcu8_pkg::F_INC: alu_op = mcu8_pkg::ALU_INC; // RQ2
                mcu8_pkg::F_DEC: alu_op = mcu8_pkg::ALU_DEC; // RQ2
                mcu8_pkg::F_CLR: alu_op = mcu8_pkg::ALU_CLR; // RQ2
                mcu8_pkg::F_ACC: begin
                    unique case (md)
                        mcu8_pkg::ACC_ROT: alu_op = mcu8_pkg::ALU_ROT;
                        mcu8_pkg::ACC_SHL: alu_op = mcu8_pkg::ALU_SHL;
                        default: alu_op = mcu8_pkg::ALU_COM;
                    endcase
                end
            endcase
        end
    end

    mcu8_alu u_alu (
        .op(alu_op),
        .a(alu_a),
        .b(opval),
        .bit_sel(op_q[2:0]),
        .c_in(flags_q.c),
        .res(alu_res),
        .z(alu_z),
        .c(alu_c),
        .z_we(alu_zwe),
        .c_we(alu_cwe)
    );

    mcu8_branch u_branch (
        .ins_pc(ins_pc_q),
        .op(op_q),
        .b2(b2_q),
        .disp(b3_q),
        .flags(flags_q),
        .bit_val(bit_val),
        .taken(br_taken),
        .target(br_target)
    );

    // data space read address per cycle
    always_comb begin
        if (cyc_q == 3'h1) begin
            rd_addr = mcu8_pkg::SD_BASE | {7'h00, md[0]};
        end else if (sd) begin
            rd_addr = mcu8_pkg::SD_BASE | {6'h00, md};
        end else if (alu_ind) begin
            rd_addr = ptr_q;
        end else begin
            rd_addr = b2_q;
        end
    end
    assign waddr_d = rd_addr;

    // program counter advance per cycle and end-of-instruction effects
    always_comb begin
        pc_d = pc_q;
        a_d = a_q;
        flags_d = flags_q; // RQ23
        wr_d = 1'b0;
        halt_d = 1'b0;
        if (run && (cyc_q == 3'h0 || (cyc_q == 3'h1 && (alu_b2 || is_ext
            || bop || bt)) || (cyc_q == 3'h2 && (alu_b3 || bt)))) begin
            pc_d = pc_q + 12'h001;
        end
        if (fin) begin
            if (is_alu || sd || bop) begin
                if (to_acc) begin
                    a_d = alu_res;
                end
                wr_d = to_mem;
                if (alu_zwe && !clr_dir) begin
                    flags_d.z = alu_z; // RQ6
                end
                if (alu_cwe && !clr_dir) begin
                    flags_d.c = alu_c; // RQ6
                end
            end
            if (bt) begin
                flags_d.c = bit_val; // RQ12
            end
            if ((is_rel || bt || is_ext) && br_taken) begin
                pc_d = br_target; // RQ8 RQ20
            end
            if (is_ret || is_iret) begin
                pc_d = stack_q[sp_q - 3'h1];
            end
            if (is_iret) begin
                flags_d = irq_flags; // RQ18
            end
            halt_d = is_ctl && !op_q[4] && (is_stop
                     || op_q[2:0] == mcu8_pkg::C_WAIT);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= S_RUN;
            cyc_q <= 3'h0;
        end else if (ce) begin
            if (run) begin
                cyc_q <= (cyc_q == 3'h0 || fin) ?
                         ((cyc_q == 3'h0) ? 3'h1 : 3'h0) : cyc_q + 3'h1;
                if (halt_d) begin
                    state_q <= S_HALT;
                end
            end else if (wake) begin
                state_q <= S_RUN;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_q <= mcu8_pkg::PC_RESET;
            ins_pc_q <= mcu8_pkg::PC_RESET;
            op_q <= 8'h00;
            b2_q <= 8'h00;
            b3_q <= 8'h00;
            ptr_q <= 8'h00;
            opnd_q <= 8'h00;
        end else if (ce && run) begin
            pc_q <= pc_d;
            if (cyc_q == 3'h0) begin
                op_q <= pm_data;
                ins_pc_q <= pc_q;
            end
            if (cyc_q == 3'h1) begin
                b2_q <= pm_data;
                ptr_q <= ds_rdata;
            end
            if (cyc_q == 3'h2) begin
                b3_q <= pm_data;
            end
            if ((cyc_q == 3'h2 && !bt) || (cyc_q == 3'h3 && bt)) begin
                opnd_q <= ds_rdata;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            a_q <= mcu8_pkg::A_RESET;
            flags_q <= '0;
        end else if (ce) begin
            a_q <= a_d;
            flags_q <= flags_d;
        end
    end

    // memory writes land in the following fetch cycle, which reads no data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 8'h00;
        end else if (ce) begin
            wr_q <= wr_d;
            if (wr_d) begin
                waddr_q <= waddr_d;
                wdata_q <= alu_res;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sp_q <= 3'h0;
        end else if (ce && fin) begin
            if (is_ext && !op_q[4] && sp_q != 3'(mcu8_pkg::STACK_DEPTH)) begin
                stack_q[sp_q] <= pc_q;
                sp_q <= sp_q + 3'h1;
            end else if ((is_ret || is_iret) && sp_q != 3'h0) begin
                sp_q <= sp_q - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stop_q <= 1'b0;
            wait_q <= 1'b0;
        end else if (ce) begin
            if (halt_d) begin
                stop_q <= is_stop && !wdog_sel; // RQ19
                wait_q <= !is_stop || wdog_sel; // RQ19
            end else if (!run && wake) begin
                stop_q <= 1'b0;
                wait_q <= 1'b0;
            end
        end
    end

    assign pm_addr = pc_q;
    assign ds_req = wr_q ? mcu8_pkg::ds_req_t'{1'b1, waddr_q, wdata_q}
                         : mcu8_pkg::ds_req_t'{1'b0, rd_addr, 8'h00};
    assign flags = flags_q;
    assign acc = a_q;
    assign lp_stop = stop_q;
    assign lp_wait = wait_q;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence stop_done;
        ce && fin && is_stop;
    endsequence

    add_imm_len_a: assert property (ce && fin && op_q == 8'hC1 |->  // RQ4
        pc_d - ins_pc_q == 12'h002 && cyc_q == 3'h3 && flags_d.z == alu_z)
        else $error("add immediate length or flags wrong");
    short_incdec_a: assert property (ce && fin && sd |->  // RQ5
        pc_d - ins_pc_q == 12'h001 && cyc_q == 3'h3
        && flags_d.c == flags_q.c && wr_d)
        else $error("short inc/dec length or carry wrong");
    clr_direct_a: assert property (ce && fin && clr_dir |->  // RQ6
        pc_d - ins_pc_q == 12'h003 && flags_d == flags_q && wr_d)
        else $error("clear direct length or flags wrong");
    shift_acc_a: assert property (ce && fin && op_q == 8'hDE |->  // RQ7
        pc_d - ins_pc_q == 12'h002 && flags_d.c == a_q[7]
        && a_d == {a_q[6:0], 1'b0})
        else $error("shift left wrong");
    short_jump_a: assert property (ce && fin && is_rel |->  // RQ9
        cyc_q == 3'h1 && flags_d == flags_q
        && pc_d == (br_taken ? br_target : ins_pc_q + 12'h001))
        else $error("short jump wrong");
    btest_carry_a: assert property (ce && fin && bt |->  // RQ12
        cyc_q == 3'h4 && flags_d.c == opnd_q[op_q[2:0]]
        && flags_d.z == flags_q.z)
        else $error("bit test carry wrong");
    bitop_flags_a: assert property (ce && fin && bop |->  // RQ15
        cyc_q == 3'h3 && flags_d == flags_q && pc_d - ins_pc_q == 12'h002)
        else $error("bit set/clear changed flags");
    ext_target_a: assert property (ce && fin && is_ext |->  // RQ22
        cyc_q == 3'h3 && pc_d == {op_q[3:0], b2_q} && flags_d == flags_q)
        else $error("jump target wrong");
    stop_wait_a: assert property (stop_done ##0 wdog_sel |=>  // RQ19
        lp_wait && !lp_stop && state_q == S_HALT)
        else $error("stop not replaced by wait");
    ctl_len_a: assert property (ce && fin && is_ctl && !sd |->  // RQ17
        cyc_q == 3'h1 && (is_iret || flags_d == flags_q))
        else $error("control instruction length or flags wrong");
endmodule
`default_nettype wire

/* File: mcu8_pkg.sv */
`default_nettype none
package mcu8_pkg;
    localparam int PC_W = 12;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic [7:0] A_RESET = 8'h00;
    localparam int STACK_DEPTH = 6;

    // opcode class in bits 7:5; bit 7 low marks a short conditional jump
    localparam logic [2:0] CLS_EXT = 3'h4;
    localparam logic [2:0] CLS_BIT = 3'h5;
    localparam logic [2:0] CLS_ALU = 3'h6;
    localparam logic [2:0] CLS_CTL = 3'h7;

    // arithmetic function in bits 4:2, operand form in bits 1:0
    localparam logic [2:0] F_ADD = 3'h0;
    localparam logic [2:0] F_AND = 3'h1;
    localparam logic [2:0] F_SUB = 3'h2;
    localparam logic [2:0] F_CMP = 3'h3;
    localparam logic [2:0] F_INC = 3'h4;
    localparam logic [2:0] F_DEC = 3'h5;
    localparam logic [2:0] F_CLR = 3'h6;
    localparam logic [2:0] F_ACC = 3'h7;
    localparam logic [1:0] M_DIR = 2'h0;
    localparam logic [1:0] M_IMM = 2'h1;
    localparam logic [1:0] M_INDX = 2'h2;
    localparam logic [1:0] M_INDY = 2'h3;
    localparam logic [1:0] ACC_COM = 2'h0;
    localparam logic [1:0] ACC_ROT = 2'h1;
    localparam logic [1:0] ACC_SHL = 2'h2;

    // control codes in bits 2:0 when bit 4 is low
    localparam logic [2:0] C_NOP = 3'h0;
    localparam logic [2:0] C_RET = 3'h1;
    localparam logic [2:0] C_IRET = 3'h2;
    localparam logic [2:0] C_STOP = 3'h3;
    localparam logic [2:0] C_WAIT = 3'h4;

    localparam logic [7:0] SD_BASE = 8'h80;
    localparam logic [11:0] BT_BIAS = 12'h002;

    localparam logic [2:0] CYC_SHORT = 3'h2;
    localparam logic [2:0] CYC_STD = 3'h4;
    localparam logic [2:0] CYC_BTEST = 3'h5;

    typedef struct packed {
        logic z;
        logic c;
    } flags_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ds_req_t;

    typedef enum logic [3:0] {
        ALU_ADD, ALU_AND, ALU_SUB, ALU_CMP, ALU_INC, ALU_DEC, ALU_CLR,
        ALU_COM, ALU_ROT, ALU_SHL, ALU_SETB, ALU_CLRB
    } alu_op_t;
endpackage
`default_nettype wire

/* File: mcu8_alu.sv */
`default_nettype none
module mcu8_alu (
    input wire mcu8_pkg::alu_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [2:0] bit_sel,
    input wire logic c_in,
    output logic [7:0] res,
    output logic z,
    output logic c,
    output logic z_we,
    output logic c_we
);
    logic [8:0] sum9;
    logic [7:0] mask;

    assign mask = 8'h01 << bit_sel;

    always_comb begin
        sum9 = 9'h000;
        res = a;
        c = c_in;
        z_we = 1'b1;
        c_we = 1'b1;
        unique case (op)
            mcu8_pkg::ALU_ADD: begin
                sum9 = {1'b0, a} + {1'b0, b};
                res = sum9[7:0];
                c = sum9[8];
            end
            mcu8_pkg::ALU_SUB, mcu8_pkg::ALU_CMP: begin
                // carry reports a borrow
                sum9 = {1'b0, a} - {1'b0, b};
                res = sum9[7:0];
                c = sum9[8];
            end
            mcu8_pkg::ALU_AND: begin
                res = a & b;
                c = 1'b0;
            end
            mcu8_pkg::ALU_INC: begin
                res = a + 8'h01;
                c_we = 1'b0; // RQ5
            end
            mcu8_pkg::ALU_DEC: begin
                res = a - 8'h01;
                c_we = 1'b0; // RQ5
            end
            mcu8_pkg::ALU_CLR: begin
                res = 8'h00;
                c = 1'b0;
            end
            mcu8_pkg::ALU_COM: begin
                res = ~a;
                c = a[7];
            end
            mcu8_pkg::ALU_ROT: {c, res} = {a, c_in};
            mcu8_pkg::ALU_SHL: {c, res} = {a, 1'b0}; // RQ7
            mcu8_pkg::ALU_SETB, mcu8_pkg::ALU_CLRB: begin
                res = (op == mcu8_pkg::ALU_SETB) ? (a | mask) : (a & ~mask);
                z_we = 1'b0; // RQ15
                c_we = 1'b0; // RQ15
            end
            default: begin
                z_we = 1'b0;
                c_we = 1'b0;
            end
        endcase
        z = (res == 8'h00);
    end
endmodule
`default_nettype wire

/* File: mcu8_branch.sv */
`default_nettype none
module mcu8_branch (
    input wire logic [11:0] ins_pc,
    input wire logic [7:0] op,
    input wire logic [7:0] b2,
    input wire logic [7:0] disp,
    input wire mcu8_pkg::flags_t flags,
    input wire logic bit_val,
    output logic taken,
    output logic [11:0] target
);
    logic is_rel;
    logic is_ext;
    logic cond;

    assign is_rel = !op[7];
    assign is_ext = (op[7:5] == mcu8_pkg::CLS_EXT);

    always_comb begin
        unique case (op[6:5])
            2'h0: cond = !flags.z; // RQ9
            2'h1: cond = !flags.c; // RQ9
            2'h2: cond = flags.z; // RQ9
            2'h3: cond = flags.c; // RQ9
        endcase
    end

    always_comb begin
        if (is_rel) begin
            taken = cond; // RQ8
            // backward by span, forward by span plus one
            target = op[4] ? ins_pc - {8'h00, op[3:0]}
                           : ins_pc + {8'h00, op[3:0]} + 12'h001; // RQ10
        end else if (is_ext) begin
            taken = 1'b1;
            target = {op[3:0], b2}; // RQ22 RQ21
        end else begin
            taken = (bit_val == op[4]); // RQ8
            target = ins_pc + mcu8_pkg::BT_BIAS
                   + {{4{disp[7]}}, disp}; // RQ13
        end
    end
endmodule
`default_nettype wire

/* File: mem_model.sv */
`default_nettype none
module mem_model (
    input wire logic clk_sys,
    input wire logic [11:0] pm_addr,
    output logic [7:0] pm_data,
    input wire mcu8_pkg::ds_req_t ds_req,
    output logic [7:0] ds_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pm [4096];
    logic [7:0] ds [256];
    // asynchronous reads, whole program space and all data locations
    assign pm_data = pm[pm_addr];
    assign ds_rdata = ds[ds_req.addr];
    always @(posedge clk_sys) begin
        if (ds_req.we === 1'b1) begin
            ds[ds_req.addr] <= ds_req.wdata;
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wdog_sel = 1'b0;
    logic wake = 1'b0;
    logic ce = 1'b1;
    mcu8_pkg::flags_t irq_flags = 2'b10;
    logic [11:0] pm_addr;
    logic [7:0] pm_data;
    logic [7:0] ds_rdata;
    logic [7:0] acc;
    mcu8_pkg::ds_req_t ds_req;
    mcu8_pkg::flags_t flags;
    logic lp_stop;
    logic lp_wait;
    int fails = 0;
    int n_checks = 0;
    logic [7:0] prog[$];

    mcu8_core dut_u (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .pm_addr(pm_addr),
        .pm_data(pm_data),
        .ds_req(ds_req),
        .ds_rdata(ds_rdata),
        .wdog_sel(wdog_sel),
        .irq_flags(irq_flags),
        .wake(wake),
        .flags(flags),
        .acc(acc),
        .lp_stop(lp_stop),
        .lp_wait(lp_wait)
    );

    mem_model mem_u (
        .clk_sys(clk_sys),
        .pm_addr(pm_addr),
        .pm_data(pm_data),
        .ds_req(ds_req),
        .ds_rdata(ds_rdata)
    );

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task finish_test;
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // hold reset and refill memory: unused program bytes complement acc
    task start;
        @(posedge clk_sys);
        #1;
        rst = 1'b1;
        for (int i = 0; i < 4096; i++) begin
            mem_u.pm[i] = 8'hDC;
        end
        for (int i = 0; i < 256; i++) begin
            mem_u.ds[i] = 8'h00;
        end
    endtask

    task load(input logic [11:0] a);
        foreach (prog[i]) begin
            mem_u.pm[a + 12'(i)] = prog[i];
        end
    endtask

    // release reset, count edges until the core halts
    task run(input int cyc, input logic [11:0] pc);
        int n;
        n = 0;
        repeat (6) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        while (lp_wait !== 1'b1 && lp_stop !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("cycles", 32'(n), 32'(cyc));
        chk("pc", 32'(pm_addr), 32'(pc));
    endtask

    task t_alu;
        start;
        prog = '{8'hC1, 8'hFF, 8'hC1, 8'h01, 8'hC0, 8'h40, 8'hDE, 8'h00,
                 8'hCD, 8'h02, 8'hE4};
        load(12'h000);
        mem_u.ds[8'h40] = 8'h81;
        run(22, 12'h00B);
        chk("alu_acc", 32'(acc), 32'h02);
        chk("alu_flags", 32'(flags), 32'h2);
    endtask

    task t_mem;
        start;
        prog = '{8'hC1, 8'h7F, 8'hDC, 8'hDD, 8'hD8, 8'hFF, 8'h00, 8'hF3,
                 8'hF9, 8'hE4};
        load(12'h000);
        mem_u.ds[8'hFF] = 8'hAA;
        mem_u.ds[8'h83] = 8'hFF;
        mem_u.ds[8'h81] = 8'h05;
        run(26, 12'h00A);
        chk("mem_acc", 32'(acc), 32'h00);
        chk("mem_flags", 32'(flags), 32'h1);
        chk("clr_ff", 32'(mem_u.ds[8'hFF]), 32'h00);
        chk("inc_83", 32'(mem_u.ds[8'h83]), 32'h00);
        chk("dec_81", 32'(mem_u.ds[8'h81]), 32'h04);
    endtask

    task t_jump;
        start;
        prog = '{8'h0F, 8'hDC, 8'hDC, 8'hE4};
        load(12'h000);
        prog = '{8'h41, 8'h61, 8'h3F};
        load(12'h010);
        run(10, 12'h004);
        chk("jr_flags", 32'(flags), 32'h0);
        start;
        prog = '{8'hC1, 8'hFF, 8'hC1, 8'h01, 8'h61, 8'hDC, 8'h41, 8'hDC,
                 8'h01, 8'h21, 8'hE4};
        load(12'h000);
        run(18, 12'h00B);
        chk("jr_acc", 32'(acc), 32'h00);
    endtask

    // bit operations target plain memory only, never port registers
    task t_bit;
        start;
        prog = '{8'hBF, 8'h20, 8'hA8, 8'hFE, 8'hB7, 8'h20, 8'h7F, 8'hA7,
                 8'h20, 8'h00, 8'hE4};
        load(12'h000);
        prog = '{8'hA0, 8'hFE, 8'h80};
        load(12'h085);
        mem_u.ds[8'hFE] = 8'hFF;
        run(25, 12'h00B);
        chk("bt_flags", 32'(flags), 32'h1);
        chk("set_20", 32'(mem_u.ds[8'h20]), 32'h80);
        chk("clr_fe", 32'(mem_u.ds[8'hFE]), 32'hFE);
    endtask

    task t_long;
        start;
        prog = '{8'h9F, 8'h00};
        load(12'h000);
        prog = '{8'h8A, 8'hBC, 8'h81, 8'h23, 8'hE4};
        load(12'hF00);
        prog = '{8'hE0, 8'hE1};
        load(12'hABC);
        prog = '{8'hE2};
        load(12'h123);
        run(20, 12'hF05);
        chk("return_from_interrupt_flags", 32'(flags), 32'h2);
    endtask

    task t_halt;
        int n;
        start;
        prog = '{8'hE3, 8'hC1, 8'h05, 8'hE4};
        load(12'h000);
        wdog_sel = 1'b1;
        run(2, 12'h001);
        chk("wd_stop", 32'(lp_stop), 32'h0);
        chk("wd_wait", 32'(lp_wait), 32'h1);
        start;
        load(12'h000);
        wdog_sel = 1'b0;
        run(2, 12'h001);
        chk("stop", 32'(lp_stop), 32'h1);
        wake = 1'b1;
        n = 0;
        while (lp_stop === 1'b1 && n < 40) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        wake = 1'b0;
        while (lp_wait !== 1'b1 && n < 80) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("wake_acc", 32'(acc), 32'h05);
    endtask

    // operands through both index registers, core frozen for four edges
    task t_ind;
        start;
        prog = '{8'hC1, 8'hFF, 8'hC6, 8'hCB, 8'hD2, 8'hD5, 8'h00, 8'hE4};
        load(12'h000);
        mem_u.ds[8'h80] = 8'h40;
        mem_u.ds[8'h81] = 8'h41;
        mem_u.ds[8'h40] = 8'h3C;
        mem_u.ds[8'h41] = 8'h3D;
        ce = 1'b0;
        fork
            run(26, 12'h008);
            begin
                repeat (10) @(posedge clk_sys);
                #1;
                ce = 1'b1;
            end
        join
        chk("ind_acc", 32'(acc), 32'hFE);
        chk("ind_flags", 32'(flags), 32'h1);
        chk("inc_ind", 32'(mem_u.ds[8'h40]), 32'h3D);
    endtask

    initial begin
        #2000000;
        fails++;
        finish_test;
    end

    initial begin
        t_alu;
        t_mem;
        t_jump;
        t_bit;
        t_long;
        t_halt;
        t_ind;
        finish_test;
    end
endmodule
`default_nettype wire
